// [logic/scss_pkg.sv]
package scss_pkg;

    // clock path in use, gray coded
    typedef enum logic [1:0] {
        scss_md_safe   = 2'h0,
        scss_md_direct = 2'h1,
        scss_md_presc  = 2'h3,
        scss_md_pll    = 2'h2
    } scss_mode_t;

endpackage

// [logic/scss_regs.svh]
`ifndef SCSS_REGS_SVH
`define SCSS_REGS_SVH

// register byte offsets
`define SCSS_CTRL_OFS       5'h00
`define SCSS_PRESC_OFS      5'h04
`define SCSS_PLL_OFS        5'h08
`define SCSS_STATUS_OFS     5'h0C

// control register fields
`define SCSS_CTRL_SEL_LSB   0
`define SCSS_CTRL_SEL_MSB   1
`define SCSS_CTRL_VCO_BIT   2
`define SCSS_CTRL_SRC_BIT   3

// prescaler register field
`define SCSS_PRESC_LSB      0
`define SCSS_PRESC_MSB      9

// pll register fields
`define SCSS_PLL_P_LSB      0
`define SCSS_PLL_P_MSB      5
`define SCSS_PLL_N_LSB      8
`define SCSS_PLL_N_MSB      15
`define SCSS_PLL_K2_LSB     16
`define SCSS_PLL_K2_MSB     25

// status register fields
`define SCSS_STAT_MODE_LSB  0
`define SCSS_STAT_MODE_MSB  1
`define SCSS_STAT_LOCK_BIT  2
`define SCSS_STAT_PER_LSB   16
`define SCSS_STAT_PER_MSB   31

// reset values
`define SCSS_SEL_RST        2'h0
`define SCSS_VCO_RST        1'h0
`define SCSS_SRC_RST        1'h0
`define SCSS_PRESC_RST      10'h000
`define SCSS_PLL_P_RST      6'h00
`define SCSS_PLL_N_RST      8'h00
`define SCSS_PLL_K2_RST     10'h000

// clock source select codes
`define SCSS_SEL_PRESC_PLL  2'h2
`define SCSS_SEL_DIRECT     2'h3

// axi responses
`define SCSS_RESP_OKAY      2'h0
`define SCSS_RESP_SLVERR    2'h2

`endif

// [logic/scss_sync.sv]
`timescale 1ns/1ps

module scss_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    // asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // scss_sync

// [logic/scss_top.sv]
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "scss_regs.svh"

// How it works
// - select 11 passes the direct clock input through undivided, duty kept.
// - prescaler path only when select is 10 and vco bypass is 1.
// - prescaler source is crystal input or internal clock, chosen by bit.
// - system clock equals source clock divided by divider field plus one.
// - factor one gives source frequency with source duty cycle.
// - largest factor is 1024, giving the slowest system clock.
// - crystal source with factor one behaves like direct drive.
// - select 10 with bypass 0 uses pll: input times (N+1) over (P+1) times (K2+1).
// - pll ratio settles gradually, system clock never jumps abruptly; here only den slews, a new N (multiplier field) applies at once.

module scss_top #(
    parameter int ADDR_W = 5,
    parameter int PER_W  = 16
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    // axi4-lite write channels
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read channels
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // clock source pins
    input  wire logic              direct_clock_input,
    input  wire logic              crystal_input,
    input  wire logic              internal_clock_input,
    // derived system clock level
    output logic                   sys_clk_out
);

    // control and configuration fields
    logic [1:0]  clock_source_select;
    logic        vco_bypass_bit;
    logic        presc_src_internal;
    logic [9:0]  prescaler_divider_field;
    logic [5:0]  pll_input_divider_field;
    logic [7:0]  pll_multiplier_field;
    logic [9:0]  pll_output_divider_field;

    // bus slave state
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              do_write;
    logic [31:0]       wr_old;
    logic [31:0]       wr_new;
    logic              wr_hit;
    logic [31:0]       rd_img;
    logic              rd_hit;

    // clock path state
    scss_pkg::scss_mode_t mode;
    scss_pkg::scss_mode_t next_mode;
    logic [2:0]       pins_s;
    logic             dir_s;
    logic             src_s;
    logic             src_d;
    logic             src_rise;
    logic [9:0]       ph;
    logic [9:0]       next_ph;
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] per_meas;
    logic [31:0]      target;
    logic [31:0]      den;
    logic [32:0]      acc;
    logic [32:0]      acc_sum;
    logic [32:0]      step;
    logic             pll_clk;
    logic             locked;
    logic             next_clk;

    assign do_write = aw_got & w_got & ~bvalid;

    // ---------------- axi4-lite write path ----------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `SCSS_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awready   <= 1'b0;
                aw_got    <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready   <= 1'b0;
                w_got    <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp  <= wr_hit ? `SCSS_RESP_OKAY : `SCSS_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                aw_got  <= 1'b0;
                w_got   <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // old image of the addressed register, merged with strobed bytes
    always_comb begin
        wr_old = 32'h0000_0000;
        wr_hit = 1'b1;
        unique case ({aw_addr_q[ADDR_W-1:2], 2'b00})
            `SCSS_CTRL_OFS:  wr_old = {28'h0, presc_src_internal,
                                       vco_bypass_bit, clock_source_select};
            `SCSS_PRESC_OFS: wr_old = {22'h0, prescaler_divider_field};
            `SCSS_PLL_OFS:   wr_old = {6'h0, pll_output_divider_field,
                                       pll_multiplier_field, 2'h0,
                                       pll_input_divider_field};
            `SCSS_STATUS_OFS: wr_hit = 1'b1;
            default:         wr_hit = 1'b0;
        endcase
        for (int i = 0; i < 4; i++) begin
            wr_new[8*i +: 8] = w_strb_q[i] ? w_data_q[8*i +: 8]
                                           : wr_old[8*i +: 8];
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            clock_source_select      <= `SCSS_SEL_RST;
            vco_bypass_bit           <= `SCSS_VCO_RST;
            presc_src_internal       <= `SCSS_SRC_RST;
            prescaler_divider_field  <= `SCSS_PRESC_RST;
            pll_input_divider_field  <= `SCSS_PLL_P_RST;
            pll_multiplier_field     <= `SCSS_PLL_N_RST;
            pll_output_divider_field <= `SCSS_PLL_K2_RST;
        end else if (do_write) begin
            unique case ({aw_addr_q[ADDR_W-1:2], 2'b00})
                `SCSS_CTRL_OFS: begin
                    clock_source_select <=
                        wr_new[`SCSS_CTRL_SEL_MSB:`SCSS_CTRL_SEL_LSB];
                    vco_bypass_bit      <= wr_new[`SCSS_CTRL_VCO_BIT];
                    presc_src_internal  <= wr_new[`SCSS_CTRL_SRC_BIT];
                end
                `SCSS_PRESC_OFS: begin
                    prescaler_divider_field <=
                        wr_new[`SCSS_PRESC_MSB:`SCSS_PRESC_LSB];
                end
                `SCSS_PLL_OFS: begin
                    pll_input_divider_field <=
                        wr_new[`SCSS_PLL_P_MSB:`SCSS_PLL_P_LSB];
                    pll_multiplier_field <=
                        wr_new[`SCSS_PLL_N_MSB:`SCSS_PLL_N_LSB];
                    pll_output_divider_field <=
                        wr_new[`SCSS_PLL_K2_MSB:`SCSS_PLL_K2_LSB];
                end
                default: begin
                end
            endcase
        end
    end

    // ---------------- axi4-lite read path ----------------
    always_comb begin
        rd_img = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case ({araddr[ADDR_W-1:2], 2'b00})
            `SCSS_CTRL_OFS:   rd_img = {28'h0, presc_src_internal,
                                        vco_bypass_bit, clock_source_select};
            `SCSS_PRESC_OFS:  rd_img = {22'h0, prescaler_divider_field};
            `SCSS_PLL_OFS:    rd_img = {6'h0, pll_output_divider_field,
                                        pll_multiplier_field, 2'h0,
                                        pll_input_divider_field};
            `SCSS_STATUS_OFS: rd_img = {per_meas, 13'h0, locked, mode};
            default:          rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `SCSS_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_img;
            rresp   <= rd_hit ? `SCSS_RESP_OKAY : `SCSS_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ---------------- pin synchronisers ----------------
    scss_sync #(.W(3)) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       ({internal_clock_input, crystal_input,
                   direct_clock_input}),
        .q       (pins_s)
    );

    assign dir_s    = pins_s[0];
    assign src_s    = presc_src_internal ? pins_s[2] : pins_s[1];
    assign src_rise = src_s & ~src_d;

    // ---------------- mode decode ----------------
    always_comb begin
        next_mode = scss_pkg::scss_md_safe;
        if (clock_source_select == `SCSS_SEL_DIRECT) begin
            next_mode = scss_pkg::scss_md_direct;
        end else if (clock_source_select == `SCSS_SEL_PRESC_PLL) begin
            next_mode = vco_bypass_bit ? scss_pkg::scss_md_presc
                                       : scss_pkg::scss_md_pll;
        end
    end

    // ---------------- prescaler ----------------
    always_comb begin
        next_ph = ph;
        // a lowered divider field must not leave the phase stranded
        if (ph > prescaler_divider_field) begin
            next_ph = 10'h000;
        end else if (src_rise) begin
            next_ph = (ph == prescaler_divider_field) ? 10'h000
                                                      : ph + 10'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            src_d <= 1'b0;
            ph    <= 10'h000;
        end else begin
            src_d <= src_s;
            ph    <= next_ph;
        end
    end

    // ---------------- pll model ----------------
    assign target = {16'h0, per_meas}
                  * {25'h0, {1'b0, pll_input_divider_field} + 7'h01}
                  * {21'h0, {1'b0, pll_output_divider_field} + 11'h001};
    assign step    = {23'h0, {1'b0, pll_multiplier_field} + 9'h001, 1'b0};
    assign acc_sum = acc + step;
    assign locked  = (den == target) && (den != 32'h0000_0000);

    // input period in system clocks
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            per_cnt  <= '0;
            per_meas <= '0;
        end else if (src_rise) begin
            per_meas <= per_cnt + PER_W'(1);
            per_cnt  <= '0;
        end else if (per_cnt != {PER_W{1'b1}}) begin
            per_cnt <= per_cnt + PER_W'(1);
        end
    end

    // ratio slews one step per cycle toward its target
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            den <= 32'h0000_0000;
        end else if (den < target) begin
            den <= den + 32'h0000_0001;
        end else if (den > target) begin
            den <= den - 32'h0000_0001;
        end
    end

    // phase accumulator toggles twice per output period
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            acc     <= 33'h0_0000_0000;
            pll_clk <= 1'b0;
        end else if (mode != scss_pkg::scss_md_pll || den == 32'h0) begin
            acc <= 33'h0_0000_0000;
        end else if (acc_sum >= {1'b0, den}) begin
            acc     <= acc_sum - {1'b0, den};
            pll_clk <= ~pll_clk;
        end else begin
            acc <= acc_sum;
        end
    end

    // ---------------- output select ----------------
    always_comb begin
        next_clk = pins_s[2];
        unique case (mode)
            scss_pkg::scss_md_direct: next_clk = dir_s;
            scss_pkg::scss_md_presc:
                next_clk = src_s & (next_ph == 10'h000);
            scss_pkg::scss_md_pll:    next_clk = pll_clk;
            scss_pkg::scss_md_safe:   next_clk = pins_s[2];
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode        <= scss_pkg::scss_md_safe;
            sys_clk_out <= 1'b0;
        end else begin
            mode        <= next_mode;
            sys_clk_out <= next_clk;
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_direct_pass: assert property (
        mode == scss_pkg::scss_md_direct |=> sys_clk_out == $past(dir_s))
        else $error("direct drive does not follow input");
    a_presc_entry: assert property (
        (clock_source_select == 2'h2 && vco_bypass_bit)
            |=> mode == scss_pkg::scss_md_presc)
        else $error("prescaler mode not entered");
    a_presc_source: assert property (
        (mode == scss_pkg::scss_md_presc && !presc_src_internal
            && prescaler_divider_field == 10'h000 && $stable(mode))
            |=> sys_clk_out == $past(pins_s[1]))
        else $error("prescaler does not use crystal source");
    a_presc_phase: assert property (
        (mode == scss_pkg::scss_md_presc && $past(mode) == mode
            && $rose(sys_clk_out)) |-> ph == 10'h000)
        else $error("prescaler output rose off phase zero");
    a_unity_duty: assert property (
        (mode == scss_pkg::scss_md_presc
            && prescaler_divider_field == 10'h000)
            |=> sys_clk_out == $past(src_s))
        else $error("unity factor changes duty cycle");
    a_presc_bound: assert property (
        ($stable(prescaler_divider_field) && $past(ph) <= prescaler_divider_field)
            |-> ph <= prescaler_divider_field)
        else $error("prescaler phase beyond divider field");
    a_crystal_like: assert property (
        (mode == scss_pkg::scss_md_presc && !presc_src_internal
            && prescaler_divider_field == 10'h000)[*2]
            |=> sys_clk_out == $past(pins_s[1]))
        else $error("crystal bypass differs from direct drive");
    a_div_width: assert property (
        (do_write && aw_addr_q[ADDR_W-1:2] == 3'h1 && w_strb_q == 4'hF)
            |=> prescaler_divider_field == $past(w_data_q[9:0]))
        else $error("divider field not ten bits");
    a_pll_path: assert property (
        (mode == scss_pkg::scss_md_pll)
            |=> sys_clk_out == $past(pll_clk))
        else $error("pll mode does not drive system clock");
    a_pll_smooth: assert property (
        den == $past(den) || den == $past(den) + 32'h1
            || den == $past(den) - 32'h1)
        else $error("pll ratio changed abruptly");

    c_direct: cover property (mode == scss_pkg::scss_md_direct
        && $rose(sys_clk_out));
    c_presc_div: cover property (mode == scss_pkg::scss_md_presc
        && prescaler_divider_field != 10'h000 && $rose(sys_clk_out));
    c_pll_lock: cover property (mode == scss_pkg::scss_md_pll && locked);
    c_slverr: cover property (rvalid && rresp == 2'h2);

endmodule // scss_top

// [tb/scss_osc_model.sv]
`timescale 1ns/1ps

// free-running clock source: low for LO cycles, high for HI cycles
module scss_osc_model #(
    parameter int HI = 2,
    parameter int LO = 4
) (
    // reference clock
    input  wire logic clk_sys,
    // source pin level
    output logic      pin
);
    // toggles on the falling edge, away from the sampling edge
    initial begin
        pin = 1'b0;
        forever begin
            repeat (LO) @(negedge clk_sys);
            pin = 1'b1;
            repeat (HI) @(negedge clk_sys);
            pin = 1'b0;
        end
    end
endmodule // scss_osc_model

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "scss_regs.svh"

module testbench;
    logic        clk_sys = 1'b0;
    logic        rst_b   = 1'b0;
    logic [4:0]  awaddr  = 5'h00;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [3:0]  wstrb   = 4'hF;
    logic        wvalid  = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready  = 1'b0;
    logic [4:0]  araddr  = 5'h00;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready  = 1'b0;
    logic        pin_direct;
    logic        pin_xtal;
    logic        pin_int;
    logic        sys_clk_out;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    logic [31:0] rd;
    logic [1:0]  rs;
    int          hi;
    int          per;
    // ctrl, divider field, mode, high time, period (0: not measured)
    int unsigned tbl [0:9][0:4] = '{
        '{32'h0, 0, 0, 4, 7},      '{32'h4, 0, 0, 4, 7},
        '{32'h3, 0, 1, 3, 8},      '{32'h7, 5, 1, 3, 8},
        '{32'h6, 0, 3, 2, 6},      '{32'hE, 2, 3, 4, 21},
        '{32'h6, 1, 3, 2, 12},     '{32'h6, 1023, 3, 2, 6144},
        '{32'h2, 0, 2, 3, 6},      '{32'hA, 0, 2, 0, 7}
    };

    always #5 clk_sys = ~clk_sys;

    // clock sources: direct period 8, crystal 6, internal 7
    scss_osc_model #(.HI(3), .LO(5)) i_scss_osc_direct (
        .clk_sys (clk_sys),
        .pin     (pin_direct)
    );
    scss_osc_model #(.HI(2), .LO(4)) i_scss_osc_xtal (
        .clk_sys (clk_sys),
        .pin     (pin_xtal)
    );
    scss_osc_model #(.HI(4), .LO(3)) i_scss_osc_int (
        .clk_sys (clk_sys),
        .pin     (pin_int)
    );

    scss_top i_scss_top (
        .clk_sys              (clk_sys),
        .rst_b                (rst_b),
        .awaddr               (awaddr),
        .awvalid              (awvalid),
        .awready              (awready),
        .wdata                (wdata),
        .wstrb                (wstrb),
        .wvalid               (wvalid),
        .wready               (wready),
        .bresp                (bresp),
        .bvalid               (bvalid),
        .bready               (bready),
        .araddr               (araddr),
        .arvalid              (arvalid),
        .arready              (arready),
        .rdata                (rdata),
        .rresp                (rresp),
        .rvalid               (rvalid),
        .rready               (rready),
        .direct_clock_input   (pin_direct),
        .crystal_input        (pin_xtal),
        .internal_clock_input (pin_int),
        .sys_clk_out          (sys_clk_out)
    );

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic axi_write(input logic [4:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk_sys);
            if (!aw_done && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (!w_done && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        do @(posedge clk_sys); while (bvalid !== 1'b1);
        r = bresp;
    endtask

    task automatic axi_read(input logic [4:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_sys); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask

    // high time and period of sys_clk_out in clk_sys cycles
    task automatic measure(output int h, output int p);
        int l;
        h = 0;
        l = 0;
        repeat (2) begin
            do @(posedge clk_sys); while (sys_clk_out !== 1'b0);
            do @(posedge clk_sys); while (sys_clk_out !== 1'b1);
        end
        while (sys_clk_out === 1'b1) begin
            h++;
            @(posedge clk_sys);
        end
        while (sys_clk_out === 1'b0) begin
            l++;
            @(posedge clk_sys);
        end
        p = h + l;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            $display("mismatch timeout expected done seen hang");
            print_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        // registers: reset values, read back, unmapped and read-only
        axi_read(`SCSS_CTRL_OFS, rd, rs);
        check("ctrl reset", rd, 32'h0000_0000);
        axi_read(`SCSS_PRESC_OFS, rd, rs);
        check("presc reset", rd, 32'h0000_0000);
        axi_write(`SCSS_PLL_OFS, 32'h03FF_FF3F, rs);
        check("pll wr resp", 32'(rs), 32'(`SCSS_RESP_OKAY));
        axi_read(`SCSS_PLL_OFS, rd, rs);
        check("pll readback", rd, 32'h03FF_FF3F);
        // unity pll ratio so its output period equals the input period
        axi_write(`SCSS_PLL_OFS, 32'h0000_0000, rs);
        check("pll unity resp", 32'(rs), 32'(`SCSS_RESP_OKAY));
        axi_write(`SCSS_PRESC_OFS, 32'h0000_03FF, rs);
        axi_read(`SCSS_PRESC_OFS, rd, rs);
        check("presc max field", rd, 32'h0000_03FF);
        wstrb <= 4'h1;
        axi_write(`SCSS_PRESC_OFS, 32'h0000_0000, rs);
        wstrb <= 4'hF;
        axi_read(`SCSS_PRESC_OFS, rd, rs);
        check("presc byte strobe", rd, 32'h0000_0300);
        axi_read(5'h10, rd, rs);
        check("unmapped rd data", rd, 32'h0000_0000);
        check("unmapped rd resp", 32'(rs), 32'(`SCSS_RESP_SLVERR));
        axi_write(5'h1C, 32'hFFFF_FFFF, rs);
        check("unmapped wr resp", 32'(rs), 32'(`SCSS_RESP_SLVERR));
        axi_write(`SCSS_STATUS_OFS, 32'hFFFF_FFFF, rs);
        check("status wr resp", 32'(rs), 32'(`SCSS_RESP_OKAY));
        axi_read(`SCSS_STATUS_OFS, rd, rs);
        check("status ro mode", 32'(rd[1:0]), 32'h0);
        $display("test registers done");
        // clock paths: mode and output waveform per setting
        for (int i = 0; i < 10; i++) begin
            axi_write(`SCSS_PRESC_OFS, 32'(tbl[i][1]), rs);
            axi_write(`SCSS_CTRL_OFS, 32'(tbl[i][0]), rs);
            axi_read(`SCSS_STATUS_OFS, rd, rs);
            check("mode", 32'(rd[1:0]), 32'(tbl[i][2]));
            if (tbl[i][4] != 0) begin
                measure(hi, per);
                if (tbl[i][3] != 0)
                    check("high time", 32'(hi), 32'(tbl[i][3]));
                check("period", 32'(per), 32'(tbl[i][4]));
            end
            if (tbl[i][2] == 2) begin
                axi_read(`SCSS_STATUS_OFS, rd, rs);
                check("pll locked", 32'(rd[2]), 32'h1);
                check("pll in period", 32'(rd[31:16]), tbl[i][4]);
            end
            $display("test clock path %0d done", i);
        end
        print_verdict();
    end
endmodule // testbench
